// ===== module_diag_serial_regs.svh
`ifndef MODULE_DIAG_SERIAL_REGS_SVH
`define MODULE_DIAG_SERIAL_REGS_SVH

// Serial slave address, 7-bit form
`define DEV_ADDR 7'h50

// Byte map
`define OFS_READING0 8'h00
`define OFS_ALARM_HI 8'h05
`define OFS_ALARM_LO 8'h06
`define OFS_WARN_HI 8'h07
`define OFS_WARN_LO 8'h08
`define OFS_FIRST_RW 8'h09
`define OFS_RATE 8'h75
`define MEM_TOP 8'h7F

`define RATE_RESET 8'h00
`define RATE_8G_BIT 0

// Factory limits, one byte per monitor, monitor 0 in the low byte
`define ALARM_HI_LIM 40'hF0_F0_F0_F0_F0
`define WARN_HI_LIM 40'hE0_E0_E0_E0_E0
`define WARN_LO_LIM 40'h20_20_20_20_20
`define ALARM_LO_LIM 40'h10_10_10_10_10

`endif

// ===== module_diag_serial_pkg.sv
`default_nettype none
package module_diag_serial_pkg;

    // Temperature, bias, tx power, rx power, supply
    typedef logic [4:0][7:0] readings_t;

    typedef struct packed {
        logic [7:0] rate;
        logic [4:0] warn_lo;
        logic [4:0] warn_hi;
        logic [4:0] alarm_lo;
        logic [4:0] alarm_hi;
        readings_t readings;
    } diag_snap_t;

    typedef struct packed {
        logic tgl;
        logic [7:0] data;
    } rate_wr_t;

    typedef enum {
        st_idle,
        st_dev,
        st_ack_dev,
        st_addr,
        st_ack_addr,
        st_wdata,
        st_ack_w,
        st_rdata,
        st_ack_r
    } link_state_t;

endpackage : module_diag_serial_pkg
`default_nettype wire

// ===== module_diag_serial_access.sv
`timescale 1ns/1ps
`default_nettype none
`include "module_diag_serial_regs.svh"
module module_diag_serial_access (
    input wire logic clock,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire module_diag_serial_pkg::readings_t readings,
    output logic fibre_channel_8g_mode
);

    function automatic logic [7:0] lim(input logic [39:0] tbl, input int i);
        return tbl[i*8 +: 8];
    endfunction : lim
    function automatic logic writable(input logic [7:0] a);
        return a >= `OFS_FIRST_RW && a <= `MEM_TOP && a != `OFS_RATE;
    endfunction : writable
    function automatic logic [7:0] next_ptr(input logic [7:0] a);
        return (a == `MEM_TOP) ? 8'h00 : a + 8'h01;
    endfunction : next_ptr
    function automatic logic [7:0] read_byte(input logic [7:0] a,
            input module_diag_serial_pkg::diag_snap_t s, input logic [7:0] m);
        logic [7:0] r;
        r = 8'h00;
        if (a < `OFS_ALARM_HI)
            r = s.readings[a[2:0]];
        else if (a == `OFS_ALARM_HI)
            r = {3'h0, s.alarm_hi};
        else if (a == `OFS_ALARM_LO)
            r = {3'h0, s.alarm_lo};
        else if (a == `OFS_WARN_HI)
            r = {3'h0, s.warn_hi};
        else if (a == `OFS_WARN_LO)
            r = {3'h0, s.warn_lo};
        else if (a == `OFS_RATE)
            r = s.rate;
        else if (a <= `MEM_TOP)
            r = m;
        return r;
    endfunction : read_byte

    // ---------------- System clock domain ----------------
    logic link_rst_reg;
    logic [7:0] rate_select_control_reg, rate_select_control_next;
    logic [4:0] alarm_hi_reg, alarm_lo_reg, warn_hi_reg, warn_lo_reg;
    logic [4:0] alarm_hi_next, alarm_lo_next, warn_hi_next, warn_lo_next;
    module_diag_serial_pkg::diag_snap_t snap_reg, snap_next;
    logic snap_tgl_reg, snap_tgl_next;
    logic [1:0] snap_ack_sync_reg;
    logic [1:0] wr_sync_reg;
    logic wr_seen_reg, wr_seen_next;
    logic wr_evt;
    logic snap_load;
    // Link-side state shared with this domain
    module_diag_serial_pkg::rate_wr_t rate_wr_reg, rate_wr_next;
    logic snap_seen_reg, snap_seen_next;
    for (genvar i = 0; i < 5; i++) begin : g_mon
        assign alarm_hi_next[i] = readings[i] > lim(`ALARM_HI_LIM, i);
        assign warn_hi_next[i] = readings[i] > lim(`WARN_HI_LIM, i);
        assign warn_lo_next[i] = readings[i] < lim(`WARN_LO_LIM, i);
        assign alarm_lo_next[i] = readings[i] < lim(`ALARM_LO_LIM, i);
    end
    assign wr_evt = wr_sync_reg[1] != wr_seen_reg;
    // New snapshot only once the link side has taken the last one
    assign snap_load = snap_ack_sync_reg[1] == snap_tgl_reg;
    always_comb begin
        rate_select_control_next = rate_select_control_reg;
        wr_seen_next = wr_sync_reg[1];
        snap_next = snap_reg;
        snap_tgl_next = snap_tgl_reg;
        // Write data sits still for a whole byte, long after the toggle lands
        if (wr_evt)
            rate_select_control_next = rate_wr_reg.data;
        if (snap_load) begin
            snap_next.readings = readings;
            snap_next.alarm_hi = alarm_hi_reg;
            snap_next.alarm_lo = alarm_lo_reg;
            snap_next.warn_hi = warn_hi_reg;
            snap_next.warn_lo = warn_lo_reg;
            snap_next.rate = rate_select_control_reg;
            snap_tgl_next = ~snap_tgl_reg;
        end
    end

    always_ff @(posedge clock) begin
        link_rst_reg <= rst;
        wr_sync_reg <= {wr_sync_reg[0], rate_wr_reg.tgl};
        snap_ack_sync_reg <= {snap_ack_sync_reg[0], snap_seen_reg};
        if (rst) begin
            rate_select_control_reg <= `RATE_RESET;
            alarm_hi_reg <= 5'h00;
            alarm_lo_reg <= 5'h00;
            warn_hi_reg <= 5'h00;
            warn_lo_reg <= 5'h00;
            snap_reg <= '0;
            snap_tgl_reg <= 1'b0;
            wr_seen_reg <= 1'b0;
        end else begin
            rate_select_control_reg <= rate_select_control_next;
            alarm_hi_reg <= alarm_hi_next;
            alarm_lo_reg <= alarm_lo_next;
            warn_hi_reg <= warn_hi_next;
            warn_lo_reg <= warn_lo_next;
            snap_reg <= snap_next;
            snap_tgl_reg <= snap_tgl_next;
            wr_seen_reg <= wr_seen_next;
        end
    end
    assign fibre_channel_8g_mode = rate_select_control_reg[`RATE_8G_BIT];
    // ---------------- Serial clock domain ----------------
    // Clocked by the host's clock, the start flag by the falling data line; it may stop between frames
    logic start_flag_reg, start_ack_reg, start_ack_next, start_clr;
    logic rx_bit_reg;
    module_diag_serial_pkg::link_state_t state_reg, state_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] tx_reg, tx_next;
    logic [7:0] ptr_reg, ptr_next;
    logic rw_reg, rw_next;
    logic sda_oe_n_reg, sda_oe_n_next;
    logic sda_out_reg;
    logic [1:0] snap_sync_reg;
    module_diag_serial_pkg::diag_snap_t snap_cap_reg, snap_cap_next;
    logic mem_we;
    logic [7:0] mem_rd;
    logic [7:0] mem [0:127];
    assign start_clr = start_ack_reg | link_rst_reg;
    // Start: data falls while the clock is high
    always_ff @(negedge sda_in or posedge start_clr) begin
        if (start_clr)
            start_flag_reg <= 1'b0;
        else if (scl_in)
            start_flag_reg <= 1'b1;
    end
    always_ff @(posedge scl_in) begin
        rx_bit_reg <= sda_in;
    end
    assign mem_rd = mem[ptr_reg[6:0]];
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg + 3'h1;
        shift_next = {shift_reg[6:0], rx_bit_reg};
        tx_next = tx_reg;
        ptr_next = ptr_reg;
        rw_next = rw_reg;
        sda_oe_n_next = 1'b1;
        rate_wr_next = rate_wr_reg;
        mem_we = 1'b0;
        start_ack_next = start_flag_reg;
        snap_seen_next = snap_sync_reg[1];
        snap_cap_next = snap_cap_reg;
        if (snap_sync_reg[1] != snap_seen_reg)
            snap_cap_next = snap_reg;
        if (start_flag_reg) begin
            // Also a repeated start; the pointer survives it
            state_next = module_diag_serial_pkg::st_dev;
            cnt_next = 3'h0;
        end else begin
            case (state_reg)
                module_diag_serial_pkg::st_dev: begin
                    if (cnt_reg == 3'h7) begin
                        if (shift_next[7:1] == `DEV_ADDR) begin
                            sda_oe_n_next = 1'b0;
                            rw_next = shift_next[0];
                            state_next = module_diag_serial_pkg::st_ack_dev;
                        end else begin
                            state_next = module_diag_serial_pkg::st_idle;
                        end
                    end
                end
                module_diag_serial_pkg::st_ack_dev: begin
                    cnt_next = 3'h0;
                    if (rw_reg) begin
                        tx_next = read_byte(ptr_reg, snap_cap_reg, mem_rd);
                        sda_oe_n_next = tx_next[7];
                        state_next = module_diag_serial_pkg::st_rdata;
                    end else begin
                        state_next = module_diag_serial_pkg::st_addr;
                    end
                end
                module_diag_serial_pkg::st_addr: begin
                    if (cnt_reg == 3'h7) begin
                        ptr_next = shift_next;
                        sda_oe_n_next = 1'b0;
                        state_next = module_diag_serial_pkg::st_ack_addr;
                    end
                end
                module_diag_serial_pkg::st_ack_addr, module_diag_serial_pkg::st_ack_w: begin
                    cnt_next = 3'h0;
                    state_next = module_diag_serial_pkg::st_wdata;
                end
                module_diag_serial_pkg::st_wdata: begin
                    if (cnt_reg == 3'h7) begin
                        sda_oe_n_next = 1'b0;
                        state_next = module_diag_serial_pkg::st_ack_w;
                        ptr_next = next_ptr(ptr_reg);
                        mem_we = writable(ptr_reg);
                        if (ptr_reg == `OFS_RATE) begin
                            rate_wr_next.tgl = ~rate_wr_reg.tgl;
                            rate_wr_next.data = shift_next;
                        end
                    end
                end
                module_diag_serial_pkg::st_rdata: begin
                    tx_next = {tx_reg[6:0], 1'b1};
                    sda_oe_n_next = tx_next[7];
                    if (cnt_reg == 3'h7) begin
                        sda_oe_n_next = 1'b1;
                        ptr_next = next_ptr(ptr_reg);
                        state_next = module_diag_serial_pkg::st_ack_r;
                    end
                end
                module_diag_serial_pkg::st_ack_r: begin
                    // Host acknowledge asks for the next byte
                    if (!rx_bit_reg) begin
                        cnt_next = 3'h0;
                        tx_next = read_byte(ptr_reg, snap_cap_reg, mem_rd);
                        sda_oe_n_next = tx_next[7];
                        state_next = module_diag_serial_pkg::st_rdata;
                    end else begin
                        state_next = module_diag_serial_pkg::st_idle;
                    end
                end
                module_diag_serial_pkg::st_idle: begin
                    cnt_next = cnt_reg;
                end
                default: state_next = module_diag_serial_pkg::st_idle;
            endcase
        end
    end

    // Reset is a registered copy of rst, so only constants load here
    always_ff @(negedge scl_in or posedge link_rst_reg) begin
        if (link_rst_reg) begin
            state_reg <= module_diag_serial_pkg::st_idle;
            cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'hFF;
            ptr_reg <= 8'h00;
            rw_reg <= 1'b0;
            sda_oe_n_reg <= 1'b1;
            sda_out_reg <= 1'b0;
            start_ack_reg <= 1'b0;
            rate_wr_reg <= '0;
            snap_sync_reg <= 2'h0;
            snap_seen_reg <= 1'b0;
            snap_cap_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            tx_reg <= tx_next;
            ptr_reg <= ptr_next;
            rw_reg <= rw_next;
            sda_oe_n_reg <= sda_oe_n_next;
            sda_out_reg <= 1'b0;
            start_ack_reg <= start_ack_next;
            rate_wr_reg <= rate_wr_next;
            snap_sync_reg <= {snap_sync_reg[0], snap_tgl_reg};
            snap_seen_reg <= snap_seen_next;
            snap_cap_reg <= snap_cap_next;
        end
    end

    // User bytes; no reset, contents are undefined until written
    always_ff @(negedge scl_in) begin
        if (mem_we)
            mem[ptr_reg[6:0]] <= shift_next;
    end
    assign sda_out = sda_out_reg;
    assign sda_oe_n = sda_oe_n_reg;
    // ---------------- Assertions ----------------
    property p_link_rdata;
        @(negedge scl_in) disable iff (link_rst_reg)
        state_reg == module_diag_serial_pkg::st_rdata |-> sda_oe_n_reg == tx_reg[7];
    endproperty
    prot_write_a: assert property (@(negedge scl_in) disable iff (link_rst_reg)
        state_reg == module_diag_serial_pkg::st_wdata && !start_flag_reg && ptr_reg < `OFS_FIRST_RW
        |-> !mem_we) else $error("write reached a protected byte");
    prot_ack_a: assert property (@(negedge scl_in) disable iff (link_rst_reg)
        state_reg == module_diag_serial_pkg::st_wdata && cnt_reg == 3'h7 && !start_flag_reg
        |=> state_reg == module_diag_serial_pkg::st_ack_w && !sda_oe_n_reg)
        else $error("written byte not acknowledged");
    read_bit_a: assert property (p_link_rdata)
        else $error("read bit differs from shift register");
    drive_window_a: assert property (@(negedge scl_in) disable iff (link_rst_reg)
        !sda_oe_n_reg |-> !sda_out_reg && state_reg inside {module_diag_serial_pkg::st_ack_dev,
        module_diag_serial_pkg::st_ack_addr, module_diag_serial_pkg::st_ack_w,
        module_diag_serial_pkg::st_rdata}) else $error("data line driven outside a module slot");
    ptr_wrap_a: assert property (@(negedge scl_in) disable iff (link_rst_reg)
        state_reg == module_diag_serial_pkg::st_rdata && cnt_reg == 3'h7 && !start_flag_reg
        && ptr_reg == `MEM_TOP |=> ptr_reg == 8'h00) else $error("pointer did not wrap at top");
    ptr_step_a: assert property (@(negedge scl_in) disable iff (link_rst_reg)
        state_reg == module_diag_serial_pkg::st_wdata && cnt_reg == 3'h7 && !start_flag_reg
        && ptr_reg < `MEM_TOP |=> ptr_reg == $past(ptr_reg) + 8'h01)
        else $error("pointer did not advance by one");
    rate_set_a: assert property (@(posedge clock) disable iff (rst)
        wr_evt && rate_wr_reg.data[`RATE_8G_BIT] |=> fibre_channel_8g_mode)
        else $error("8G mode not entered");
    rate_clear_a: assert property (@(posedge clock) disable iff (rst)
        wr_evt && !rate_wr_reg.data[`RATE_8G_BIT] |=> !fibre_channel_8g_mode)
        else $error("10G mode not restored");
    reset_rate_a: assert property (@(posedge clock)
        rst |=> !fibre_channel_8g_mode && rate_select_control_reg == `RATE_RESET)
        else $error("rate byte not cleared by reset");
    alarm_flag_a: assert property (@(posedge clock) disable iff (rst)
        readings[0] > lim(`ALARM_HI_LIM, 0) && readings[0] < lim(`WARN_LO_LIM, 0) == 1'b0
        |=> alarm_hi_reg[0] && warn_hi_reg[0]) else $error("high alarm flag missing");
    snap_take_a: assert property (@(posedge clock) disable iff (rst)
        snap_load |=> snap_reg.readings == $past(readings) && snap_tgl_reg != $past(snap_tgl_reg))
        else $error("snapshot did not take readings");

    rate_write_c: cover property (@(posedge clock) disable iff (rst) wr_evt);
    read_byte_c: cover property (@(negedge scl_in) disable iff (link_rst_reg)
        state_reg == module_diag_serial_pkg::st_ack_r);
    seq_write_c: cover property (@(negedge scl_in) disable iff (link_rst_reg)
        state_reg == module_diag_serial_pkg::st_ack_w ##9 state_reg == module_diag_serial_pkg::st_ack_w);
endmodule : module_diag_serial_access
`default_nettype wire

// ===== host_serial_master.sv
`timescale 1ns/1ps
`default_nettype none
module host_serial_master (
    input wire logic sda_wire,
    output logic scl,
    output logic sda_drv
);
    localparam int QTR = 8;

    // Clock parked high between frames, data line released
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // Data only moves while the clock is low, except in start and stop
    task automatic start_c();
        #QTR sda_drv = 1'b1;
        #QTR scl = 1'b1;
        #QTR sda_drv = 1'b0;
        #QTR scl = 1'b0;
    endtask : start_c

    task automatic stop_c();
        #QTR sda_drv = 1'b0;
        #QTR scl = 1'b1;
        #QTR sda_drv = 1'b1;
        #QTR;
    endtask : stop_c

    task automatic send(input logic [7:0] b, output logic ack_n);
        for (int i = 7; i >= 0; i--) begin
            #QTR sda_drv = b[i];
            #QTR scl = 1'b1;
            #(2 * QTR) scl = 1'b0;
        end
        #QTR sda_drv = 1'b1;
        #QTR scl = 1'b1;
        ack_n = sda_wire;
        #(2 * QTR) scl = 1'b0;
    endtask : send

    task automatic recv(input logic ack_n, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            #QTR sda_drv = 1'b1;
            #QTR scl = 1'b1;
            b[i] = sda_wire;
            #(2 * QTR) scl = 1'b0;
        end
        #QTR sda_drv = ack_n;
        #QTR scl = 1'b1;
        #(2 * QTR) scl = 1'b0;
    endtask : recv
endmodule : host_serial_master
`default_nettype wire

// ===== test_module_diag_serial_access.sv
`timescale 1ns/1ps
`default_nettype none
`include "module_diag_serial_regs.svh"
module test_module_diag_serial_access;
    logic clock;
    logic rst;
    logic scl;
    logic sda_drv;
    logic sda_out;
    logic sda_oe_n;
    logic sda_wire;
    logic fibre_channel_8g_mode;
    module_diag_serial_pkg::readings_t readings;
    int error_cnt;
    int checks_done;
    logic [7:0] rx_q[$];

    // Pull-up on the line: any party may pull it low
    assign sda_wire = sda_drv & (sda_oe_n | sda_out);

    module_diag_serial_access u_module_diag_serial_access (.clock(clock), .rst(rst), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .readings(readings),
        .fibre_channel_8g_mode(fibre_channel_8g_mode));
    host_serial_master u_host_serial_master (.sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic finish_test();
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    function automatic logic [4:0] beyond(input module_diag_serial_pkg::readings_t r,
                                          input logic [39:0] lim, input logic hi);
        for (int i = 0; i < 5; i++) beyond[i] = hi ? (r[i] > lim[i*8 +: 8]) : (r[i] < lim[i*8 +: 8]);
    endfunction : beyond

    task automatic put(input logic [7:0] b);
        logic a;
        u_host_serial_master.send(b, a);
        check({7'h00, a}, 8'h00, "missing ack");
    endtask : put

    task automatic wr(input logic [7:0] addr, input logic [7:0] data[$]);
        u_host_serial_master.start_c();
        put({`DEV_ADDR, 1'b0});
        put(addr);
        foreach (data[i]) put(data[i]);
        u_host_serial_master.stop_c();
    endtask : wr

    // Random read, or current-address read when cur is set
    task automatic rd(input logic [7:0] addr, input int n, input logic cur);
        logic [7:0] b;
        u_host_serial_master.start_c();
        if (!cur) begin
            put({`DEV_ADDR, 1'b0});
            put(addr);
            u_host_serial_master.start_c();
        end
        put({`DEV_ADDR, 1'b1});
        rx_q = {};
        for (int i = 0; i < n; i++) begin
            u_host_serial_master.recv(i == n - 1, b);
            rx_q.push_back(b);
        end
        u_host_serial_master.stop_c();
    endtask : rd

    task automatic wait_mode(input logic exp);
        // Look at the mode off the edge that launches it
        for (int k = 0; k < 20 && fibre_channel_8g_mode !== exp; k++) @(negedge clock);
        check({7'h00, fibre_channel_8g_mode}, {7'h00, exp}, "rate mode");
    endtask : wait_mode

    // Dummy read first: the snapshot only refreshes on serial activity
    // User bytes hold no value until written, so the dummy read uses a defined byte
    task automatic check_block();
        rd(`OFS_RATE, 1, 1'b0);
        rd(`OFS_READING0, 9, 1'b0);
        for (int i = 0; i < 5; i++) check(rx_q[i], readings[i], "reading");
        check(rx_q[5], {3'b000, beyond(readings, `ALARM_HI_LIM, 1'b1)}, "alarm high");
        check(rx_q[6], {3'b000, beyond(readings, `ALARM_LO_LIM, 1'b0)}, "alarm low");
        check(rx_q[7], {3'b000, beyond(readings, `WARN_HI_LIM, 1'b1)}, "warn high");
        check(rx_q[8], {3'b000, beyond(readings, `WARN_LO_LIM, 1'b0)}, "warn low");
    endtask : check_block

    task automatic do_reset();
        @(negedge clock);
        rst = 1'b1;
        repeat (5) @(negedge clock);
        rst = 1'b0;
        repeat (4) @(negedge clock);
    endtask : do_reset

    task automatic foreign_frame();
        logic nack;
        u_host_serial_master.start_c();
        u_host_serial_master.send({`DEV_ADDR ^ 7'h02, 1'b0}, nack);
        check({7'h00, nack}, 8'h01, "foreign address acked");
        u_host_serial_master.stop_c();
    endtask : foreign_frame

    initial begin
        #200000;
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        finish_test();
    end

    initial begin
        error_cnt = 0;
        checks_done = 0;
        rst = 1'b1;
        // Edge values: F0 is only a warning, 20 is in range, 0F is an alarm
        readings = 40'hF0_0F_20_E1_F1;
        do_reset();
        check({7'h00, fibre_channel_8g_mode}, 8'h00, "mode after reset");
        wr(`OFS_RATE, {8'hFF});
        wait_mode(1'b1);
        wr(`OFS_RATE, {8'hFE});
        wait_mode(1'b0);
        wr(`OFS_RATE, {8'h01});
        wait_mode(1'b1);
        wr(8'h7E, {8'hA5, 8'h5A, 8'h3C});
        wr(`OFS_ALARM_HI, {8'h1F});
        rd(`OFS_RATE, 1, 1'b0);
        rd(`OFS_RATE, 1, 1'b0);
        check(rx_q[0], 8'h01, "rate readback");
        check_block();
        rd(8'h7E, 2, 1'b0);
        check(rx_q[0], 8'hA5, "user byte 7E");
        check(rx_q[1], 8'h5A, "user byte 7F");
        rd(8'h00, 1, 1'b1);
        check(rx_q[0], readings[0], "current read after wrap");
        @(negedge clock);
        readings = 40'h05_21_F1_E0_10;
        check_block();
        foreign_frame();
        do_reset();
        check({7'h00, fibre_channel_8g_mode}, 8'h00, "mode after second reset");
        foreign_frame();
        rd(`OFS_RATE, 1, 1'b0);
        rd(`OFS_RATE, 1, 1'b0);
        check(rx_q[0], `RATE_RESET, "rate byte after reset");
        finish_test();
    end
endmodule : test_module_diag_serial_access
`default_nettype wire
